// File: src/svd_params.svh
// register map, field positions and level codes of the supply level detector
`ifndef SVD_PARAMS_SVH
`define SVD_PARAMS_SVH
`define SVD_CTRL_ADDR  16'h1800
`define SVD_CLR_ADDR   16'h1804
`define SVD_SET_ADDR   16'h1808
`define SVD_INV_ADDR   16'h180c
`define SVD_STAT_ADDR  16'h1810
`define SVD_MASK_ADDR  16'h1814
`define SVD_ON_BIT     15
`define SVD_DIR_BIT    11
`define SVD_BG_BIT     10
`define SVD_ONE_BIT    9
`define SVD_EVT_BIT    8
`define SVD_GATE_BIT   7
`define SVD_LVL_MSB    3
`define SVD_LVL_LSB    0
`define SVD_LVL_EXT    4'hf
`define SVD_LVL_HI     4'ha
`define SVD_LVL_LO     4'h4
`define SVD_INT_EVT    0
`define SVD_INT_BG     1
`define SVD_INT_W      2
`define SVD_RST_CTRL   32'h0000_0000
`endif

// File: src/svd_pkg.sv
// types shared by the supply level detector control block
package svd_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   typedef enum logic [1:0] {OP_WRITE, OP_CLR, OP_SET, OP_INV} alias_op_t;

   typedef struct packed {
      logic       enable;
      logic       dir;
      logic [3:0] level;
      logic       extSel;
   } analog_cfg_t;

   typedef struct packed {
      logic        on;
      logic        dir;
      logic        gate;
      logic [3:0]  level;
      logic        evt;
      logic        aboveS1;
      logic        aboveS2;
      logic        belowS1;
      logic        belowS2;
      logic        bgS1;
      logic        bgS2;
      logic        bgPrev;
      logic [1:0]  intStatus;
      logic [1:0]  intMask;
      logic [31:0] rdata;
   } state_t;
endpackage

// File: src/supply_voltage_detect_control.sv
// control, status and event logic of the supply level detector
// What this block does
// - while enabled, a detection event blocks flash programming.
// - a detection event is signalled as a non-maskable interrupt request.
// - control bit 15 enables the detector except its band-gap status, reset value 0.
// - bit 11 picks the event: 1 supply at or above trip, 0 at or below.
// - bit 10 shows band-gap stable, readable also while disabled.
// - bit 9 always reads 1 and ignores writes.
// - bit 8 is the hardware-managed event flag, 1 while the event is on.
// - writing 1 to bit 7 with bit 15 set opens the comparator gate, sticky until disable.
// - bit 7 resets to 0 and is held 0 while the detector is off.
// - bits 3..0 pick the trip level; 1111 external, 1010..0100 internal.
// - clear, set and invert aliases at +0x4, +0x8, +0xc apply a mask.
// - bits 31..16, 14..12 and 6..4 read 0 and ignore writes.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "svd_params.svh"

module supply_voltage_detect_control (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire svd_pkg::bus_req_t busIn,
   output logic [31:0]            rdata,
   input  wire logic              supplyAtOrAbove,
   input  wire logic              supplyAtOrBelow,
   input  wire logic              bandgapStableIn,
   output svd_pkg::analog_cfg_t   analogCfg,
   output logic                   compGateOpen,
   output logic                   nmiReq,
   output logic                   flashProgInhibit,
   output logic                   irq
);
   import svd_pkg::*;

   state_t st_ff;
   state_t nxt_st;

   // writable control bits only; everything else is rebuilt on read
   localparam logic [31:0] CTRL_WMASK = (32'h1 << `SVD_ON_BIT)
      | (32'h1 << `SVD_DIR_BIT) | (32'h1 << `SVD_GATE_BIT)
      | (32'hf << `SVD_LVL_LSB);

   function automatic logic [31:0] ctrlWord(input state_t s);
      logic [31:0] w;
      w = 32'h0;
      w[`SVD_ON_BIT]  = s.on;
      w[`SVD_DIR_BIT] = s.dir;
      w[`SVD_BG_BIT]  = s.bgS2;
      w[`SVD_ONE_BIT] = 1'b1;
      w[`SVD_EVT_BIT] = s.evt;
      w[`SVD_GATE_BIT] = s.gate;
      w[`SVD_LVL_MSB:`SVD_LVL_LSB] = s.level;
      return w;
   endfunction

   function automatic logic [31:0] applyAlias(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input alias_op_t   op);
      logic [31:0] r;
      r = old;
      case (op)
         OP_WRITE: r = data;
         OP_CLR:   r = old & ~data;
         OP_SET:   r = old | data;
         OP_INV:   r = old ^ data;
         default:  r = old;
      endcase
      return r;
   endfunction

   function automatic logic levelValid(input logic [3:0] lvl);
      // reserved codes never raise an event
      return (lvl == `SVD_LVL_EXT)
         || ((lvl >= `SVD_LVL_LO) && (lvl <= `SVD_LVL_HI));
   endfunction

   logic        ctlHit;
   alias_op_t   ctlOp;
   logic [31:0] oldCtl;
   logic [31:0] newCtl;
   logic        cond;
   logic [1:0]  intSet;

   always_comb begin
      ctlHit = 1'b1;
      ctlOp  = OP_WRITE;
      case (busIn.addr)
         `SVD_CTRL_ADDR: ctlOp = OP_WRITE;
         `SVD_CLR_ADDR:  ctlOp = OP_CLR;
         `SVD_SET_ADDR:  ctlOp = OP_SET;
         `SVD_INV_ADDR:  ctlOp = OP_INV;
         default:        ctlHit = 1'b0;
      endcase

      nxt_st = st_ff;
      // first stages feed only the second stages
      nxt_st.aboveS1 = supplyAtOrAbove;
      nxt_st.aboveS2 = st_ff.aboveS1;
      nxt_st.belowS1 = supplyAtOrBelow;
      nxt_st.belowS2 = st_ff.belowS1;
      nxt_st.bgS1    = bandgapStableIn;
      nxt_st.bgS2    = st_ff.bgS1;
      nxt_st.bgPrev  = st_ff.bgS2;

      // the analog side reports both relations; equal supply sets both
      cond = st_ff.dir ? st_ff.aboveS2 : st_ff.belowS2;
      nxt_st.evt = st_ff.on && st_ff.gate && levelValid(st_ff.level)
         && cond;

      oldCtl = ctrlWord(st_ff) & CTRL_WMASK;
      newCtl = applyAlias(oldCtl, busIn.wdata & CTRL_WMASK, ctlOp);
      if (busIn.wr && ctlHit) begin
         nxt_st.on    = newCtl[`SVD_ON_BIT];
         nxt_st.dir   = newCtl[`SVD_DIR_BIT];
         nxt_st.level = newCtl[`SVD_LVL_MSB:`SVD_LVL_LSB];
         // a zero never clears the gate; only disabling does
         nxt_st.gate  = newCtl[`SVD_ON_BIT]
            && (st_ff.gate || newCtl[`SVD_GATE_BIT]);
      end
      if (!nxt_st.on) begin
         nxt_st.gate = 1'b0;
      end

      if (busIn.wr && (busIn.addr == `SVD_MASK_ADDR)) begin
         nxt_st.intMask = busIn.wdata[`SVD_INT_W-1:0];
      end

      intSet = '0;
      intSet[`SVD_INT_EVT] = nxt_st.evt && !st_ff.evt;
      intSet[`SVD_INT_BG]  = st_ff.bgPrev && !st_ff.bgS2;
      // read clears, but a set in the same cycle survives
      if (busIn.rd && (busIn.addr == `SVD_STAT_ADDR)) begin
         nxt_st.intStatus = intSet;
      end else begin
         nxt_st.intStatus = st_ff.intStatus | intSet;
      end

      nxt_st.rdata = 32'h0;
      if (busIn.rd) begin
         if (ctlHit) begin
            nxt_st.rdata = ctrlWord(st_ff);
         end else if (busIn.addr == `SVD_STAT_ADDR) begin
            nxt_st.rdata = {30'h0, st_ff.intStatus};
         end else if (busIn.addr == `SVD_MASK_ADDR) begin
            nxt_st.rdata = {30'h0, st_ff.intMask};
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata            = st_ff.rdata;
   assign analogCfg.enable = st_ff.on;
   assign analogCfg.dir    = st_ff.dir;
   assign analogCfg.level  = st_ff.level;
   assign analogCfg.extSel = (st_ff.level == `SVD_LVL_EXT);
   assign compGateOpen     = st_ff.gate;
   assign nmiReq           = st_ff.evt;
   // flag drops one edge after disable, so the enable is ANDed in to end the inhibit with it
   assign flashProgInhibit = st_ff.evt && st_ff.on;
   assign irq              = |(st_ff.intStatus & st_ff.intMask);

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_INHIBIT_ON_EVENT: assert property (
      $rose(st_ff.evt) && st_ff.on |-> flashProgInhibit)
      else $error("event did not block flash programming");

   AST_NMI_ON_EVENT: assert property (
      $rose(st_ff.evt) |-> nmiReq ##1 (nmiReq || !st_ff.evt))
      else $error("event did not raise the nmi request");

   AST_ON_WRITE: assert property (
      busIn.wr && busIn.addr == `SVD_CTRL_ADDR
      |=> st_ff.on == $past(busIn.wdata[`SVD_ON_BIT]))
      else $error("enable bit did not follow the write");

   AST_DIR_ABOVE: assert property (
      $rose(st_ff.evt) && $past(st_ff.dir) |-> $past(supplyAtOrAbove, 3))
      else $error("rising event without supply at or above trip");

   AST_BG_READ: assert property (
      busIn.rd && busIn.addr == `SVD_CTRL_ADDR
      |=> rdata[`SVD_BG_BIT] == $past(st_ff.bgS2))
      else $error("band-gap status read wrong");

   AST_CTRL_FIXED_BITS: assert property (
      busIn.rd && busIn.addr == `SVD_CTRL_ADDR
      |=> rdata[`SVD_ONE_BIT] && (rdata[31:16] == 16'h0)
          && (rdata[14:12] == 3'h0) && (rdata[6:4] == 3'h0))
      else $error("unimplemented control bits read wrong");

   AST_EVT_CAUSE: assert property (
      $rose(st_ff.evt) |-> $past(st_ff.on) && $past(st_ff.gate))
      else $error("event flag set without enable and gate");

   AST_GATE_STICKY: assert property (
      st_ff.gate ##1 st_ff.on |-> st_ff.gate)
      else $error("gate cleared while still enabled");

   AST_GATE_OFF: assert property (
      !st_ff.on |-> !st_ff.gate ##1 !st_ff.evt)
      else $error("gate open while disabled");

   AST_RESERVED_LEVEL: assert property (
      $rose(st_ff.evt) |-> levelValid($past(st_ff.level)))
      else $error("event on a reserved trip level");

   AST_SET_ALIAS: assert property (
      busIn.wr && busIn.addr == `SVD_SET_ADDR
      |=> st_ff.on == ($past(st_ff.on) | $past(busIn.wdata[`SVD_ON_BIT])))
      else $error("set alias did not or into the enable");

   AST_SYNC_DEPTH: assert property (
      $rose(st_ff.evt) && !$past(st_ff.dir) |-> $past(supplyAtOrBelow, 3))
      else $error("event not preceded by synchronised comparator");

   AST_STATUS_CLEAR: assert property (
      busIn.rd && busIn.addr == `SVD_STAT_ADDR && !$rose(nxt_st.evt)
      && !(st_ff.bgPrev && !st_ff.bgS2)
      |=> st_ff.intStatus == 2'h0 && rdata[1:0] == $past(st_ff.intStatus))
      else $error("status read did not clear");

   // the pin sampled two edges back is what the second stage holds now
   AST_EVT_RISES_ABOVE: assert property (
      st_ff.on && st_ff.gate && st_ff.dir && levelValid(st_ff.level)
      && $past(supplyAtOrAbove, 2) |=> st_ff.evt)
      else $error("event missed with supply at or above trip");

   AST_EVT_RISES_BELOW: assert property (
      st_ff.on && st_ff.gate && !st_ff.dir && levelValid(st_ff.level)
      && $past(supplyAtOrBelow, 2) |=> st_ff.evt)
      else $error("event missed with supply at or below trip");

   AST_EVT_FALLS: assert property (
      st_ff.evt && !(st_ff.dir ? $past(supplyAtOrAbove, 2)
                                : $past(supplyAtOrBelow, 2))
      |=> !st_ff.evt)
      else $error("event flag stayed up after the condition ended");

   // the flag reads the enable of the cycle before, so it drops one edge late
   AST_FLAG_CLEARS_OFF: assert property (
      !st_ff.on |=> !st_ff.evt)
      else $error("event flag held while disabled");

   AST_STATUS_SET: assert property (
      $rose(st_ff.evt) |-> st_ff.intStatus[`SVD_INT_EVT])
      else $error("event rise did not set the status bit");

   AST_NO_INHIBIT_OFF: assert property (
      !st_ff.on |-> !flashProgInhibit)
      else $error("flash programming blocked while disabled");

   // aliases and the plain address share one decoder; each gets a check
   AST_DIR_WRITE: assert property (
      busIn.wr && busIn.addr == `SVD_CTRL_ADDR
      |=> st_ff.dir == $past(busIn.wdata[`SVD_DIR_BIT]))
      else $error("direction bit did not follow the write");

   AST_LEVEL_WRITE: assert property (
      busIn.wr && busIn.addr == `SVD_CTRL_ADDR
      |=> st_ff.level == $past(busIn.wdata[`SVD_LVL_MSB:`SVD_LVL_LSB]))
      else $error("trip level did not follow the write");

   AST_CLR_ALIAS: assert property (
      busIn.wr && busIn.addr == `SVD_CLR_ADDR
      |=> st_ff.on == ($past(st_ff.on) && !$past(busIn.wdata[`SVD_ON_BIT])))
      else $error("clear alias did not mask the enable");

   AST_INV_ALIAS: assert property (
      busIn.wr && busIn.addr == `SVD_INV_ADDR
      |=> st_ff.dir == ($past(st_ff.dir) ^ $past(busIn.wdata[`SVD_DIR_BIT])))
      else $error("invert alias did not flip the direction");

   AST_GATE_OPEN: assert property (
      busIn.wr && busIn.addr == `SVD_SET_ADDR && busIn.wdata[`SVD_ON_BIT]
      && busIn.wdata[`SVD_GATE_BIT] |=> st_ff.gate)
      else $error("gate did not open on enable and gate set");

   AST_GATE_NEEDS_ON: assert property (
      st_ff.gate |-> st_ff.on)
      else $error("gate open without enable");

   // interrupt side: status and mask are this block's own additions
   AST_MASK_WRITE: assert property (
      busIn.wr && busIn.addr == `SVD_MASK_ADDR
      |=> st_ff.intMask == $past(busIn.wdata[`SVD_INT_W-1:0]))
      else $error("mask did not follow the write");

   AST_IRQ_MASKED: assert property (
      st_ff.intMask == 2'h0 |-> !irq)
      else $error("interrupt raised with every source masked");

   // read data must not linger, so a stray sample reads zero
   AST_RDATA_IDLE: assert property (
      !busIn.rd |=> rdata == 32'h0)
      else $error("read data stood outside the read answer");

endmodule // supply_voltage_detect_control

// File: verification/supply_comparator_model.sv
// behavioural supply comparator and band-gap reference at the far side
`timescale 1ns/1ps
module supply_comparator_model
   import svd_pkg::*;
(
   input  wire svd_pkg::analog_cfg_t cfg,
   input  wire logic [11:0]          supplyMv,
   input  wire logic [11:0]          extMv,
   input  wire logic                 bgOk,
   output logic                      atOrAbove,
   output logic                      atOrBelow,
   output logic                      bgStable
);
   logic [11:0] tripMv;
   logic [11:0] seenMv;
   // reserved codes still give a live compare so the block must refuse them
   always_comb begin
      case (cfg.level)
         4'ha: tripMv = 12'h960;
         4'h9: tripMv = 12'h9c4;
         4'h8: tripMv = 12'ha89;
         4'h7: tripMv = 12'hae7;
         4'h6: tripMv = 12'hbb8;
         4'h5: tripMv = 12'hcd8;
         4'h4: tripMv = 12'hdc9;
         4'hf: tripMv = 12'h4b0;
         default: tripMv = 12'hfff;
      endcase
   end
   assign seenMv = cfg.extSel ? extMv : supplyMv;
   // both outputs high at equality, disabled comparator rests low
   assign atOrAbove = cfg.enable && (seenMv >= tripMv);
   assign atOrBelow = cfg.enable && (seenMv <= tripMv);
   assign bgStable  = bgOk;
endmodule // supply_comparator_model

// File: verification/supply_voltage_detect_control_test.sv
// self-checking bench of the supply level detector control block
`timescale 1ns/1ps
`include "svd_params.svh"
module supply_voltage_detect_control_test;
   import svd_pkg::*;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   bus_req_t    busIn = '0;
   logic [31:0] rdata;
   logic [11:0] supplyMv = 12'hce4;
   logic [11:0] extMv = 12'h000;
   logic        bgOk = 1'b1;
   logic        above, below, bgStable, gateOpen, nmiReq, inhibit, irq;
   analog_cfg_t analogCfg;
   int          mismatches = 0;
   int          checks = 0;
   logic        expEvt;

   always #2.5 clock = ~clock;

   supply_voltage_detect_control i_supply_voltage_detect_control (
      .clock(clock), .rst(rst), .busIn(busIn), .rdata(rdata),
      .supplyAtOrAbove(above), .supplyAtOrBelow(below),
      .bandgapStableIn(bgStable), .analogCfg(analogCfg),
      .compGateOpen(gateOpen), .nmiReq(nmiReq),
      .flashProgInhibit(inhibit), .irq(irq));

   supply_comparator_model i_supply_comparator_model (
      .cfg(analogCfg), .supplyMv(supplyMv), .extMv(extMv), .bgOk(bgOk),
      .atOrAbove(above), .atOrBelow(below), .bgStable(bgStable));

   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic busWrite(logic [15:0] addr, logic [31:0] data);
      @(posedge clock);
      busIn <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      busIn.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic busRead(logic [15:0] addr, logic [31:0] exp);
      @(posedge clock);
      busIn <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      busIn.rd <= 1'b0;
      #1;
      chk("rdata", exp, rdata);
   endtask

   task automatic settle();
      repeat (5) @(posedge clock);
      #1;
   endtask

   task automatic complete_run();
      if (mismatches == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      settle();
      busRead(`SVD_CTRL_ADDR, 32'h0000_0600);
      busWrite(`SVD_CTRL_ADDR, 32'hffff_ffff);
      busRead(`SVD_CTRL_ADDR, 32'h0000_8e8f);
      busWrite(`SVD_CLR_ADDR, 32'h0000_0080);
      busRead(`SVD_CTRL_ADDR, 32'h0000_8e8f);
      busWrite(`SVD_CLR_ADDR, 32'h0000_8000);
      busRead(`SVD_CTRL_ADDR, 32'h0000_0e0f);
      // direction flips only while off, so no false event can follow
      busWrite(`SVD_INV_ADDR, 32'h0000_0800);
      busRead(`SVD_CTRL_ADDR, 32'h0000_060f);
      busWrite(`SVD_SET_ADDR, 32'h0000_0080);
      busRead(`SVD_CTRL_ADDR, 32'h0000_060f);
      chk("extSel", 32'h1, 32'(analogCfg.extSel));
      busWrite(16'h1820, 32'hffff_ffff);
      busRead(16'h1820, 32'h0000_0000);
      busWrite(`SVD_MASK_ADDR, 32'h0000_0001);
      busRead(`SVD_MASK_ADDR, 32'h0000_0001);
      // level is only touched while off, as software must; the supply sits
      // above the external trip so only a working external select fires
      supplyMv = 12'h7d0;
      extMv = 12'h3e8;
      for (int c = 0; c < 16; c++) begin
         expEvt = (c == 15) || (c >= 4 && c <= 10);
         busWrite(`SVD_CTRL_ADDR, 32'(c));
         busWrite(`SVD_SET_ADDR, 32'h0000_8080);
         settle();
         chk("extSel", 32'(c == 15), 32'(analogCfg.extSel));
         chk("nmiReq", 32'(expEvt), 32'(nmiReq));
         chk("inhibit", 32'(expEvt), 32'(inhibit));
         chk("irq", 32'(expEvt), 32'(irq));
         busRead(`SVD_STAT_ADDR, 32'(expEvt));
         chk("irq", 32'h0, 32'(irq));
         busWrite(`SVD_CLR_ADDR, 32'h0000_8000);
         @(posedge clock);
         #1;
         chk("inhibit", 32'h0, 32'(inhibit));
      end
      supplyMv = 12'h960;
      busWrite(`SVD_MASK_ADDR, 32'h0000_0000);
      busWrite(`SVD_CTRL_ADDR, 32'h0000_000a);
      busWrite(`SVD_SET_ADDR, 32'h0000_8080);
      settle();
      chk("irq", 32'h0, 32'(irq));
      busRead(`SVD_CTRL_ADDR, 32'h0000_878a);
      busWrite(`SVD_CLR_ADDR, 32'h0000_8000);
      busWrite(`SVD_INV_ADDR, 32'h0000_0800);
      busWrite(`SVD_SET_ADDR, 32'h0000_8080);
      settle();
      busRead(`SVD_CTRL_ADDR, 32'h0000_8f8a);
      supplyMv = 12'h3e8;
      settle();
      busRead(`SVD_CTRL_ADDR, 32'h0000_8e8a);
      chk("gate", 32'h1, 32'(gateOpen));
      busRead(`SVD_STAT_ADDR, 32'h0000_0001);
      bgOk = 1'b0;
      settle();
      busRead(`SVD_CTRL_ADDR, 32'h0000_8a8a);
      busRead(`SVD_STAT_ADDR, 32'h0000_0002);
      complete_run();
   end
endmodule // supply_voltage_detect_control_test
